// >>> common/pt_consts.svh
// register offsets, field positions, reset values and prescale counts of the paired timer
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
`ifndef PT_CONSTS_SVH
`define PT_CONSTS_SVH

`define PT_OFF_LCTL    8'h00
`define PT_OFF_UCTL    8'h04
`define PT_OFF_LCNT    8'h08
`define PT_OFF_UCNT    8'h0C
`define PT_OFF_LPER    8'h10
`define PT_OFF_UPER    8'h14
`define PT_OFF_STAT    8'h18
`define PT_OFF_CLR     8'h1C
`define PT_OFF_IEN     8'h20

`define PT_BIT_RUN     15
`define PT_BIT_SIDL    13
`define PT_BIT_GATE    6
`define PT_BIT_PS_HI   5
`define PT_BIT_PS_LO   4
`define PT_BIT_PAIR    3
`define PT_BIT_CS      1

`define PT_BIT_IRQ_LO  0
`define PT_BIT_IRQ_HI  1

`define PT_LCTL_MASK   16'hA07A
`define PT_UCTL_MASK   16'hA072
`define PT_CTL_RESET   16'h0000
`define PT_CNT_RESET   16'h0000
`define PT_PER_RESET   16'hFFFF

`define PT_PS_LAST_1   8'h00
`define PT_PS_LAST_8   8'h07
`define PT_PS_LAST_64  8'h3F
`define PT_PS_LAST_256 8'hFF

`define PT_RESP_OKAY   2'b00
`define PT_RESP_SLVERR 2'b10

`endif

// >>> common/pt_pkg.sv
// types shared by the paired timer modules
package pt_pkg;
  typedef logic [15:0] pt_word_t;
  typedef logic [1:0]  pt_ps_t;
endpackage

// >>> common/pt_src_if.sv
// control and tick bundle between the timer core and one prescaler
`timescale 1ns/1ns
interface pt_src_if;
  logic             enable;
  logic             clk_src;
  logic             gate_en;
  logic             ext_lvl;
  logic             gate_lvl;
  pt_pkg::pt_ps_t   ps;
  logic             tick;
  modport ctl (output enable, clk_src, gate_en, ext_lvl, gate_lvl, ps, input tick);
  modport pre (input enable, clk_src, gate_en, ext_lvl, gate_lvl, ps, output tick);
endinterface

// >>> src/pt_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module pt_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= '0;
      dout     <= '0;
    end else if (clk_en) begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end
endmodule // pt_sync

// >>> src/pt_prescaler.sv
// source selection, gating and prescale divider for one timer
`timescale 1ns/1ns
`include "pt_consts.svh"
module pt_prescaler (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic clk_en,
  pt_src_if.pre     src
);
  logic       ext_d_reg;
  logic [7:0] div_reg;
  logic       tick_reg;
  logic       event_in;
  logic [7:0] last;

  // pin edge, ungated, or instruction clock, optionally gated
  always_comb begin
    if (src.clk_src) begin
      event_in = src.ext_lvl & ~ext_d_reg;
    end else begin
      event_in = src.gate_en ? src.gate_lvl : 1'b1;
    end
  end

  // terminal count of the divider
  always_comb begin
    case (src.ps)
      2'd0:    last = `PT_PS_LAST_1;
      2'd1:    last = `PT_PS_LAST_8;
      2'd2:    last = `PT_PS_LAST_64;
      default: last = `PT_PS_LAST_256;
    endcase
  end

  // edge history runs always so enabling does not see a false edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_d_reg <= 1'b0;
    end else if (clk_en) begin
      ext_d_reg <= src.ext_lvl;
    end
  end

  // divider restarts from zero whenever the timer is stopped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_reg  <= 8'h00;
      tick_reg <= 1'b0;
    end else if (clk_en) begin
      if (!src.enable) begin
        div_reg  <= 8'h00;
        tick_reg <= 1'b0;
      end else if (event_in && div_reg >= last) begin
        div_reg  <= 8'h00;
        tick_reg <= 1'b1;
      end else if (event_in) begin
        div_reg  <= div_reg + 8'h01;
        tick_reg <= 1'b0;
      end else begin
        tick_reg <= 1'b0;
      end
    end
  end

  assign src.tick = tick_reg;
endmodule // pt_prescaler

// >>> src/pt_top.sv
// paired 16/32-bit timer with an AXI4-Lite register slave and one interrupt
`timescale 1ns/1ns
`include "pt_consts.svh"
module pt_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  input  wire logic        idle_mode,
  input  wire logic        ext_clock_pin_lower,
  input  wire logic        ext_clock_pin_upper,
  input  wire logic        gate_pin_lower,
  input  wire logic        gate_pin_upper,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq,
  output logic [15:0]      lower_count_out,
  output logic [15:0]      upper_count_out
);
  //----------------------------------------------------------------------------
  // declarations
  //----------------------------------------------------------------------------
  pt_pkg::pt_word_t lower_control_reg;
  pt_pkg::pt_word_t upper_control_reg;
  pt_pkg::pt_word_t lower_count_reg;
  pt_pkg::pt_word_t upper_count_reg;
  pt_pkg::pt_word_t lower_period_reg;
  pt_pkg::pt_word_t upper_period_reg;
  logic [1:0]       irq_status_reg;
  logic [1:0]       irq_status_next;
  logic [1:0]       irq_enable_reg;
  logic             irq_reg;

  logic [7:0]       awaddr_reg;
  logic [31:0]      wdata_reg;
  logic [3:0]       wstrb_reg;
  logic             awready_reg;
  logic             wready_reg;
  logic             bvalid_reg;
  logic [1:0]       bresp_reg;
  logic [7:0]       araddr_reg;
  logic             arready_reg;
  logic             rvalid_reg;
  logic [31:0]      rdata_reg;
  logic [1:0]       rresp_reg;

  logic             wr_fire;
  logic             wr_mapped;
  logic             rd_fire;
  logic             rd_mapped;
  logic [31:0]      rd_mux;
  pt_pkg::pt_word_t wr_word;

  logic [3:0]       pins_sync;
  logic             pair_as_32bit;
  logic             lower_tick;
  logic             upper_tick;
  logic             match_lo;
  logic             match_hi;
  logic             match_32;
  logic             hit_lo;
  logic             hit_hi;
  logic [31:0]      count_32_inc;

  pt_src_if lower_src ();
  pt_src_if upper_src ();

  //----------------------------------------------------------------------------
  // pin synchronisation and prescalers
  //----------------------------------------------------------------------------
  // external clock and gate pins come from outside the clock domain
  pt_sync #(.WIDTH(4)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clk_en  (clk_en),
    .din     ({gate_pin_upper, gate_pin_lower, ext_clock_pin_upper, ext_clock_pin_lower}),
    .dout    (pins_sync)
  );

  assign pair_as_32bit = lower_control_reg[`PT_BIT_PAIR];

  // lower timer governs the pair as well as itself
  assign lower_src.enable   = lower_control_reg[`PT_BIT_RUN] &
                              ~(lower_control_reg[`PT_BIT_SIDL] & idle_mode);
  assign lower_src.clk_src  = lower_control_reg[`PT_BIT_CS];
  assign lower_src.gate_en  = lower_control_reg[`PT_BIT_GATE];
  assign lower_src.ext_lvl  = pins_sync[0];
  assign lower_src.gate_lvl = pins_sync[2];
  assign lower_src.ps       = lower_control_reg[`PT_BIT_PS_HI:`PT_BIT_PS_LO];

  // upper prescaler is held off when paired, so its controls do nothing
  assign upper_src.enable   = ~pair_as_32bit & upper_control_reg[`PT_BIT_RUN] &
                              ~(upper_control_reg[`PT_BIT_SIDL] & idle_mode);
  assign upper_src.clk_src  = upper_control_reg[`PT_BIT_CS];
  assign upper_src.gate_en  = upper_control_reg[`PT_BIT_GATE];
  assign upper_src.ext_lvl  = pins_sync[1];
  assign upper_src.gate_lvl = pins_sync[3];
  assign upper_src.ps       = upper_control_reg[`PT_BIT_PS_HI:`PT_BIT_PS_LO];

  pt_prescaler u_pre_lower (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clk_en  (clk_en),
    .src     (lower_src)
  );

  pt_prescaler u_pre_upper (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clk_en  (clk_en),
    .src     (upper_src)
  );

  assign lower_tick = lower_src.tick;
  assign upper_tick = upper_src.tick;

  //----------------------------------------------------------------------------
  // counters and period compare
  //----------------------------------------------------------------------------
  assign match_lo     = (lower_count_reg == lower_period_reg);
  assign match_hi     = (upper_count_reg == upper_period_reg);
  assign match_32     = ({upper_count_reg, lower_count_reg} ==
                         {upper_period_reg, lower_period_reg});
  assign count_32_inc = {upper_count_reg, lower_count_reg} + 32'h0000_0001;

  // in paired mode only the upper flag reports the match
  assign hit_lo = ~pair_as_32bit & lower_tick & match_lo;
  assign hit_hi = pair_as_32bit ? (lower_tick & match_32) : (upper_tick & match_hi);

  // a software write to a count register overrides a tick in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lower_count_reg <= `PT_CNT_RESET;
      upper_count_reg <= `PT_CNT_RESET;
    end else if (clk_en) begin
      if (pair_as_32bit && lower_tick) begin
        if (match_32) begin
          lower_count_reg <= 16'h0000;
          upper_count_reg <= 16'h0000;
        end else begin
          lower_count_reg <= count_32_inc[15:0];
          upper_count_reg <= count_32_inc[31:16];
        end
      end else if (!pair_as_32bit) begin
        if (lower_tick) begin
          lower_count_reg <= match_lo ? 16'h0000 : lower_count_reg + 16'h0001;
        end
        if (upper_tick) begin
          upper_count_reg <= match_hi ? 16'h0000 : upper_count_reg + 16'h0001;
        end
      end
      if (wr_fire && awaddr_reg == `PT_OFF_LCNT) begin
        lower_count_reg <= wr_word;
      end
      if (wr_fire && awaddr_reg == `PT_OFF_UCNT) begin
        upper_count_reg <= wr_word;
      end
    end
  end

  assign lower_count_out = lower_count_reg;
  assign upper_count_out = upper_count_reg;

  //----------------------------------------------------------------------------
  // control and period registers
  //----------------------------------------------------------------------------
  // byte lanes 0 and 1 carry the 16-bit registers
  assign wr_word = {wstrb_reg[1] ? wdata_reg[15:8] : 8'h00,
                    wstrb_reg[0] ? wdata_reg[7:0]  : 8'h00};

  // unimplemented control bits are never stored, so they read as zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lower_control_reg <= `PT_CTL_RESET;
      upper_control_reg <= `PT_CTL_RESET;
    end else if (clk_en && wr_fire) begin
      if (awaddr_reg == `PT_OFF_LCTL) begin
        lower_control_reg <= wr_word & `PT_LCTL_MASK;
      end
      if (awaddr_reg == `PT_OFF_UCTL) begin
        upper_control_reg <= wr_word & `PT_UCTL_MASK;
      end
    end
  end

  // periods reset to all ones so a fresh timer runs the full range
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lower_period_reg <= `PT_PER_RESET;
      upper_period_reg <= `PT_PER_RESET;
    end else if (clk_en && wr_fire) begin
      if (awaddr_reg == `PT_OFF_LPER) begin
        lower_period_reg <= wr_word;
      end
      if (awaddr_reg == `PT_OFF_UPER) begin
        upper_period_reg <= wr_word;
      end
    end
  end

  //----------------------------------------------------------------------------
  // interrupt status, clear and enable
  //----------------------------------------------------------------------------
  // a match in the cycle of a clear still leaves the flag set
  always_comb begin
    irq_status_next = irq_status_reg;
    if (wr_fire && awaddr_reg == `PT_OFF_CLR && wstrb_reg[0]) begin
      irq_status_next = irq_status_reg & ~wdata_reg[1:0];
    end
    irq_status_next[`PT_BIT_IRQ_LO] = irq_status_next[`PT_BIT_IRQ_LO] | hit_lo;
    irq_status_next[`PT_BIT_IRQ_HI] = irq_status_next[`PT_BIT_IRQ_HI] | hit_hi;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_reg <= 2'b00;
      irq_enable_reg <= 2'b00;
      irq_reg        <= 1'b0;
    end else if (clk_en) begin
      irq_status_reg <= irq_status_next;
      if (wr_fire && awaddr_reg == `PT_OFF_IEN && wstrb_reg[0]) begin
        irq_enable_reg <= wdata_reg[1:0];
      end
      irq_reg <= |(irq_status_reg & irq_enable_reg); // one cycle behind the status
    end
  end

  assign irq = irq_reg;

  //----------------------------------------------------------------------------
  // AXI4-Lite write channel
  //----------------------------------------------------------------------------
  assign wr_fire   = ~awready_reg & ~wready_reg & ~bvalid_reg;
  assign wr_mapped = (awaddr_reg == `PT_OFF_LCTL) || (awaddr_reg == `PT_OFF_UCTL) ||
                     (awaddr_reg == `PT_OFF_LCNT) || (awaddr_reg == `PT_OFF_UCNT) ||
                     (awaddr_reg == `PT_OFF_LPER) || (awaddr_reg == `PT_OFF_UPER) ||
                     (awaddr_reg == `PT_OFF_STAT) || (awaddr_reg == `PT_OFF_CLR)  ||
                     (awaddr_reg == `PT_OFF_IEN);

  // address and data are taken in either order; readies reopen after the response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `PT_RESP_OKAY;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
    end else if (clk_en) begin
      if (s_axi_awvalid && awready_reg) begin
        awaddr_reg  <= {s_axi_awaddr[7:2], 2'b00};
        awready_reg <= 1'b0;
      end
      if (s_axi_wvalid && wready_reg) begin
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
        wready_reg <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_mapped ? `PT_RESP_OKAY : `PT_RESP_SLVERR;
      end
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;

  //----------------------------------------------------------------------------
  // AXI4-Lite read channel
  //----------------------------------------------------------------------------
  assign rd_fire = ~arready_reg & ~rvalid_reg;

  // the clear register is write only and reads as zero
  always_comb begin
    rd_mux    = 32'h0000_0000;
    rd_mapped = 1'b1;
    case (araddr_reg)
      `PT_OFF_LCTL: rd_mux = {16'h0000, lower_control_reg};
      `PT_OFF_UCTL: rd_mux = {16'h0000, upper_control_reg};
      `PT_OFF_LCNT: rd_mux = {16'h0000, lower_count_reg};
      `PT_OFF_UCNT: rd_mux = {16'h0000, upper_count_reg};
      `PT_OFF_LPER: rd_mux = {16'h0000, lower_period_reg};
      `PT_OFF_UPER: rd_mux = {16'h0000, upper_period_reg};
      `PT_OFF_STAT: rd_mux = {30'h0000_0000, irq_status_reg};
      `PT_OFF_CLR:  rd_mux = 32'h0000_0000;
      `PT_OFF_IEN:  rd_mux = {30'h0000_0000, irq_enable_reg};
      default:      rd_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      araddr_reg  <= 8'h00;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= `PT_RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && arready_reg) begin
        araddr_reg  <= {s_axi_araddr[7:2], 2'b00};
        arready_reg <= 1'b0;
      end
      if (rd_fire) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rd_mux;
        rresp_reg  <= rd_mapped ? `PT_RESP_OKAY : `PT_RESP_SLVERR;
      end
      if (rvalid_reg && s_axi_rready) begin
        rvalid_reg  <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
endmodule // pt_top

// >>> test/pt_checker.sv
// concurrent checks on the paired timer top ports
`timescale 1ns/1ns
module pt_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        irq,
  input wire logic [15:0] lower_count_out,
  input wire logic [15:0] upper_count_out
);
  // ------------
  // bus handshake
  // ------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // answers come on the second edge after the take, never on the first
  sequence b_late;
    ##1 !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  sequence r_late;
    ##1 !s_axi_rvalid ##1 s_axi_rvalid;
  endsequence
  AST_AW_CLOSE: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("awready stayed open after take");
  AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> b_late) else $error("write response timing wrong");
  AST_B_STAND: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
    $stable(s_axi_bresp)) else $error("write response dropped early");
  AST_B_REOPEN: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid &&
    s_axi_awready && s_axi_wready) else $error("write channel not reopened");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |-> r_late)
    else $error("read data timing wrong");
  AST_R_STAND: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
    $stable(s_axi_rdata)) else $error("read data dropped early");
  // ------------
  // counters
  // ------------
  AST_RST_VAL: assert property ($rose(aresetn) |-> !irq && !s_axi_bvalid &&
    !s_axi_rvalid && lower_count_out == 16'h0000 && upper_count_out == 16'h0000)
    else $error("bad state after reset");
  // a count only steps by one, wraps to zero, or takes a register write
  AST_LCNT_STEP: assert property ($changed(lower_count_out) |->
    lower_count_out == 16'h0000 || $rose(s_axi_bvalid) ||
    lower_count_out == $past(lower_count_out) + 16'h0001) else $error("lower count jumped");
  AST_UCNT_STEP: assert property ($changed(upper_count_out) |->
    upper_count_out == 16'h0000 || $rose(s_axi_bvalid) ||
    upper_count_out == $past(upper_count_out) + 16'h0001) else $error("upper count jumped");
endmodule // pt_checker

bind pt_top pt_checker chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .irq, .lower_count_out, .upper_count_out);

// >>> test/pt_top_tb_top.sv
// self-checking bench for the paired timer
`timescale 1ns/1ns
`include "pt_consts.svh"
module pt_top_tb_top;
  logic        aclk, aresetn, idle, ecl, ecu, gtl, gtu, irq, cen;
  logic        awv, awr, wv, wrdy, bv, brdy, arv, arr, rv, rrdy;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdata;
  logic [1:0]  bresp, rresp;
  logic [15:0] lcnt, ucnt;
  int          mismatches, compares;
  localparam logic [31:0] C_RUN = 32'h0000_8000;
  localparam logic [31:0] C_SIDL = 32'h0000_2000;
  localparam logic [31:0] C_GATE = 32'h0000_0040;
  localparam logic [31:0] C_PAIR = 32'h0000_0008;
  localparam logic [31:0] C_CS = 32'h0000_0002;

  // clk_en is driven so that freezing can be exercised
  pt_top dut_u (.aclk(aclk), .aresetn(aresetn), .clk_en(cen), .idle_mode(idle),
    .ext_clock_pin_lower(ecl), .ext_clock_pin_upper(ecu), .gate_pin_lower(gtl),
    .gate_pin_upper(gtu), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rrdy), .irq(irq), .lower_count_out(lcnt),
    .upper_count_out(ucnt));

  // 10 MHz clock
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // ------------
  // shared tasks
  // ------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic end_sim();
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // each bus task lets an edge pass first, so no signal is set twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awv && awr === 1'b1) awv <= 1'b0;
      if (wv && wrdy === 1'b1) wv <= 1'b0;
      if (bv === 1'b1) break;
    end
    brdy <= 1'b0;
    chk(bresp, e);
    if (n == 50) begin
      mismatches++;
      end_sim();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] e, output logic [31:0] d);
    int n;
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arr === 1'b1) arv <= 1'b0;
      if (rv === 1'b1) break;
    end
    rrdy <= 1'b0;
    d = rdata;
    chk(rresp, e);
    if (n == 50) begin
      mismatches++;
      end_sim();
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, `PT_RESP_OKAY, v);
    chk(v, e);
  endtask

  // counts that depend on sync and prescaler phase are judged inside a window
  task automatic rng(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
    logic [31:0] v;
    rd(a, `PT_RESP_OKAY, v);
    chk(32'(v >= lo && v <= hi), 32'h0000_0001);
  endtask

  // ------------
  // scenarios
  // ------------
  task automatic t_regs();
    logic [31:0] v;
    rchk(`PT_OFF_LCTL, 32'h0000_0000);
    rchk(`PT_OFF_UCTL, 32'h0000_0000);
    rchk(`PT_OFF_LPER, 32'h0000_FFFF);
    wr(`PT_OFF_LCTL, 32'hFFFF_FFFF, `PT_RESP_OKAY);
    rchk(`PT_OFF_LCTL, 32'h0000_A07A);
    wr(`PT_OFF_LCTL, 32'h0000_0000, `PT_RESP_OKAY);
    wr(`PT_OFF_UCTL, 32'hFFFF_FFFF, `PT_RESP_OKAY);
    rchk(`PT_OFF_UCTL, 32'h0000_A072);
    wr(`PT_OFF_UCTL, 32'h0000_0000, `PT_RESP_OKAY);
    wr(8'h40, 32'h0000_1234, `PT_RESP_SLVERR);
    rd(8'h40, `PT_RESP_SLVERR, v);
    chk(v, 32'h0000_0000);
    wr(`PT_OFF_STAT, 32'h0000_0003, `PT_RESP_OKAY);
    rchk(`PT_OFF_STAT, 32'h0000_0000);
  endtask

  // each prescale code over a fixed run; the upper timer must not move
  task automatic t_pre();
    int dv[4] = '{1, 8, 64, 256};
    for (int c = 0; c < 4; c++) begin
      wr(`PT_OFF_LCNT, 32'h0000_0000, `PT_RESP_OKAY);
      wr(`PT_OFF_UCNT, 32'h0000_0000, `PT_RESP_OKAY);
      wr(`PT_OFF_LCTL, C_RUN | (c << 4), `PT_RESP_OKAY);
      repeat (512) @(posedge aclk);
      wr(`PT_OFF_LCTL, 32'h0000_0000, `PT_RESP_OKAY);
      rng(`PT_OFF_LCNT, 512 / dv[c], 520 / dv[c] + 1);
      rchk(`PT_OFF_UCNT, 32'h0000_0000);
    end
  endtask

  task automatic t_idle();
    wr(`PT_OFF_LCNT, 32'h0000_0000, `PT_RESP_OKAY);
    wr(`PT_OFF_UCNT, 32'h0000_0000, `PT_RESP_OKAY);
    idle <= 1'b1;
    wr(`PT_OFF_LCTL, C_RUN | C_SIDL, `PT_RESP_OKAY);
    wr(`PT_OFF_UCTL, C_RUN, `PT_RESP_OKAY);
    repeat (100) @(posedge aclk);
    wr(`PT_OFF_LCTL, 32'h0000_0000, `PT_RESP_OKAY);
    wr(`PT_OFF_UCTL, 32'h0000_0000, `PT_RESP_OKAY);
    idle <= 1'b0;
    rchk(`PT_OFF_LCNT, 32'h0000_0000);
    rng(`PT_OFF_UCNT, 100, 120);
  endtask

  task automatic t_gate();
    wr(`PT_OFF_LCNT, 32'h0000_0000, `PT_RESP_OKAY);
    wr(`PT_OFF_LCTL, C_RUN | C_GATE, `PT_RESP_OKAY);
    repeat (50) @(posedge aclk);
    rchk(`PT_OFF_LCNT, 32'h0000_0000);
    gtl <= 1'b1;
    repeat (50) @(posedge aclk);
    gtl <= 1'b0;
    repeat (10) @(posedge aclk);
    rng(`PT_OFF_LCNT, 45, 55);
    wr(`PT_OFF_LCTL, 32'h0000_0000, `PT_RESP_OKAY);
    wr(`PT_OFF_LCNT, 32'h0000_0000, `PT_RESP_OKAY);
    wr(`PT_OFF_LPER, 32'h0000_0006, `PT_RESP_OKAY);
    wr(`PT_OFF_LCTL, C_RUN | C_GATE | C_CS, `PT_RESP_OKAY);
    // the pin is taken as already routed to this timer
    for (int n = 0; n < 10; n++) begin
      ecl <= 1'b1;
      repeat (3) @(posedge aclk);
      ecl <= 1'b0;
      repeat (3) @(posedge aclk);
    end
    repeat (8) @(posedge aclk);
    rchk(`PT_OFF_LCNT, 32'h0000_0003);
    rchk(`PT_OFF_STAT, 32'h0000_0001);
    wr(`PT_OFF_CLR, 32'h0000_0001, `PT_RESP_OKAY);
    wr(`PT_OFF_LCTL, 32'h0000_0000, `PT_RESP_OKAY);
  endtask

  // paired run: a low-word-only compare would flag early in the first phase
  task automatic t_pair();
    int n;
    wr(`PT_OFF_LPER, 32'h0000_FFF4, `PT_RESP_OKAY);
    wr(`PT_OFF_UPER, 32'h0000_0001, `PT_RESP_OKAY);
    wr(`PT_OFF_LCNT, 32'h0000_FFF0, `PT_RESP_OKAY);
    wr(`PT_OFF_UCNT, 32'h0000_0000, `PT_RESP_OKAY);
    wr(`PT_OFF_IEN, 32'h0000_0002, `PT_RESP_OKAY);
    wr(`PT_OFF_UCTL, C_RUN | C_SIDL | C_GATE | 32'h0000_0030, `PT_RESP_OKAY);
    idle <= 1'b1;
    wr(`PT_OFF_LCTL, C_RUN | C_PAIR, `PT_RESP_OKAY);
    repeat (30) @(posedge aclk);
    wr(`PT_OFF_LCTL, C_PAIR, `PT_RESP_OKAY);
    chk(irq, 32'h0000_0000);
    rchk(`PT_OFF_UCNT, 32'h0000_0001);
    chk(ucnt, 32'h0000_0001);
    rng(`PT_OFF_LCNT, 8, 40);
    wr(`PT_OFF_LCNT, 32'h0000_FFF0, `PT_RESP_OKAY);
    wr(`PT_OFF_LCTL, C_RUN | C_PAIR, `PT_RESP_OKAY);
    for (n = 0; n < 50 && irq !== 1'b1; n++) @(posedge aclk);
    chk(32'(n < 50), 32'h0000_0001);
    wr(`PT_OFF_LCTL, C_PAIR, `PT_RESP_OKAY);
    rchk(`PT_OFF_UCNT, 32'h0000_0000);
    rng(`PT_OFF_LCNT, 0, 8);
    rchk(`PT_OFF_STAT, 32'h0000_0002);
    wr(`PT_OFF_IEN, 32'h0000_0000, `PT_RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk(irq, 32'h0000_0000);
    wr(`PT_OFF_IEN, 32'h0000_0002, `PT_RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk(irq, 32'h0000_0001);
    wr(`PT_OFF_CLR, 32'h0000_0002, `PT_RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk(irq, 32'h0000_0000);
    rchk(`PT_OFF_STAT, 32'h0000_0000);
    wr(`PT_OFF_LCTL, 32'h0000_0000, `PT_RESP_OKAY);
    idle <= 1'b0;
  endtask

  // a running count must hold still while clk_en is low
  task automatic t_frz();
    logic [15:0] c;
    wr(`PT_OFF_LCTL, C_RUN, `PT_RESP_OKAY);
    cen <= 1'b0;
    @(posedge aclk);
    c = lcnt;
    repeat (20) @(posedge aclk);
    chk(lcnt, c);
    cen <= 1'b1;
    wr(`PT_OFF_LCTL, 32'h0000_0000, `PT_RESP_OKAY);
  endtask

  // reset, then the scenarios in turn
  initial begin
    {aresetn, idle, ecl, ecu, gtl, gtu, awv, wv, brdy, arv, rrdy} = '0;
    cen = 1'b1;
    {awa, ara, wd} = '0;
    mismatches = 0;
    compares = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_pre();
    t_idle();
    t_frz();
    t_gate();
    t_pair();
    end_sim();
  end
endmodule // pt_top_tb_top
